// ---- dv/hmc_core_model.sv ----
// Behavioural processor core that issues the halt instruction and port writes.
`timescale 1ns/1ps
module hmc_core_model (
    // Clock.
    input  wire logic  clk_sys_i,
    // Requests to the controller.
    output logic       halt_o,
    output logic       we_o,
    output logic [7:0] wd_o
);
    // Idle at time zero, so nothing is requested before reset ends.
    initial begin
        {halt_o, we_o, wd_o} = '0;
    end
    // No register write can enter HALT; only this one-cycle pulse does.
    task automatic halt();
        halt_o <= 1'b1;
        @(posedge clk_sys_i);
        halt_o <= 1'b0;
    endtask
    // One-cycle port latch write, taken at the next edge.
    task automatic wr(input logic [7:0] d);
        we_o <= 1'b1;
        wd_o <= d;
        @(posedge clk_sys_i);
        we_o <= 1'b0;
    endtask
endmodule

// ---- dv/hmc_halt_ctrl_asserts.sv ----
// Port-level assertions of the HALT-mode controller.
`timescale 1ns/1ps
module hmc_halt_ctrl_asserts import hmc_pkg::*; #(parameter int unsigned PORT_W = 8) (
    // Clock, reset and core side.
    input wire logic              clk_sys_i,
    input wire logic              rst_i,
    input wire logic              halt_instr_i,
    input wire hmc_src_t          cpu_src_i,
    input wire logic              irq_pending_i,
    input wire logic              osc_nonstop_i,
    // Gating outputs.
    input wire logic              cpu_clk_en_o,
    input wire logic              osc_run_o,
    input wire logic              tmr16_en_o,
    input wire logic              wdt_en_o,
    input wire logic              in_halt_o,
    input wire logic [PORT_W-1:0] port_out_o
);
    // One domain; the wake cycle is excluded from entry since it refuses halts.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_in; halt_instr_i && !irq_pending_i && !in_halt_o && !$past(in_halt_o)
        |=> in_halt_o && !cpu_clk_en_o; endproperty
    a_in: assert property (p_in) else $error("halt not taken");
    property p_no; !halt_instr_i && !in_halt_o |=> !in_halt_o; endproperty
    a_no: assert property (p_no) else $error("halt without pulse");
    property p_gate; in_halt_o |-> !cpu_clk_en_o && osc_run_o; endproperty
    a_gate: assert property (p_gate) else $error("core clock runs");
    property p_wake; in_halt_o && irq_pending_i |=> (!in_halt_o && cpu_clk_en_o) [*2]; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_blk; halt_instr_i && irq_pending_i |=> !in_halt_o; endproperty
    a_blk: assert property (p_blk) else $error("halt taken with irq");
    property p_hs; $rose(in_halt_o) && $past(cpu_src_i) != HMC_SRC_INTERNAL_OSC
        |-> tmr16_en_o && wdt_en_o; endproperty
    a_hs: assert property (p_hs) else $error("timer stopped");
    property p_wdt; $rose(in_halt_o) && $past(cpu_src_i) == HMC_SRC_INTERNAL_OSC
        |-> wdt_en_o == $past(osc_nonstop_i); endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");
    property p_port; in_halt_o && $past(in_halt_o) |-> $stable(port_out_o); endproperty
    a_port: assert property (p_port) else $error("port latch moved");
    // Main scenarios reached.
    c_halt: cover property ($rose(in_halt_o));
    c_wake: cover property (in_halt_o && irq_pending_i);
    c_blk: cover property (halt_instr_i && irq_pending_i && !in_halt_o);
endmodule
bind hmc_halt_ctrl hmc_halt_ctrl_asserts #(.PORT_W(PORT_W)) u_chk (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .halt_instr_i  (halt_instr_i),
    .cpu_src_i     (cpu_src_i),
    .irq_pending_i (irq_pending_i),
    .osc_nonstop_i (osc_nonstop_i),
    .cpu_clk_en_o  (cpu_clk_en_o),
    .osc_run_o     (osc_run_o),
    .tmr16_en_o    (tmr16_en_o),
    .wdt_en_o      (wdt_en_o),
    .in_halt_o     (in_halt_o),
    .port_out_o    (port_out_o)
);

// ---- dv/hmc_halt_ctrl_tb.sv ----
// Self-checking bench of the HALT-mode controller with a core model.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module hmc_halt_ctrl_tb import hmc_pkg::*; ;
    // Design inputs, each given a value at time zero, then the outputs.
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, irq_pending_i = 1'b0, osc_nonstop_i = 1'b0;
    logic        timer50_running_i = 1'b0, itb_div7_sel_i = 1'b0, itb_sub_sel_i = 1'b0;
    logic        timer51_ext_count_pin = 1'b0, halt_instr_i, port_we_i;
    logic [7:0]  port_wdata_i, port_out_o;
    hmc_src_t    cpu_src_i = HMC_SRC_HIGH_SPEED;
    logic        cpu_clk_en_o, osc_run_o, tmr16_en_o, tmr50_en_o, tmr51_en_o, timer51_count_o;
    logic        interval_timer_a_en_o, interval_timer_b_en_o, wdt_en_o, in_halt_o;
    wire  [5:0]  en = {tmr16_en_o, tmr50_en_o, tmr51_en_o, interval_timer_a_en_o,
                       interval_timer_b_en_o, wdt_en_o};
    int          err_total = 0, checks_done = 0, cyc = 0, n = 0;
    // Rows: source, nonstop, timer50 running, div7, other select, expected enables.
    logic [11:0] rows [6] = '{12'h03f, 12'h83f, 12'h400, 12'h787, 12'h6c1, 12'h504};
    hmc_halt_ctrl uut (.*);
    hmc_core_model core (.clk_sys_i(clk_sys_i), .halt_o(halt_instr_i), .we_o(port_we_i),
                         .wd_o(port_wdata_i));
    // Clock at 100 MHz.
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // A hang is cut short at cycle 1000, well past the fewer than 50 cycles the run needs.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("TB: checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Interrupt held one cycle in HALT; everything must run again.
    task automatic wake();
        @(posedge clk_sys_i);
        irq_pending_i <= 1'b1;
        @(posedge clk_sys_i);
        irq_pending_i <= 1'b0;
        #1;
        `CHK({in_halt_o, cpu_clk_en_o, en}, 8'h7f)
    endtask
    // Reset, table of entry cases, then the awkward cases.
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        `CHK({in_halt_o, cpu_clk_en_o, en, port_out_o, timer51_count_o}, 17'h0_fe00)
        foreach (rows[i]) begin
            @(posedge clk_sys_i);
            cpu_src_i <= hmc_src_t'(rows[i][11:10]);
            // Software keeps to guaranteed timer clocks.
            {osc_nonstop_i, timer50_running_i, itb_div7_sel_i, itb_sub_sel_i} <= rows[i][9:6];
            core.halt();
            #1;
            `CHK({in_halt_o, cpu_clk_en_o, osc_run_o}, 3'h5)
            `CHK(en, rows[i][5:0])
            wake();
        end
        // Halt with an interrupt already pending is refused.
        @(posedge clk_sys_i);
        irq_pending_i <= 1'b1;
        core.halt();
        #1;
        `CHK(in_halt_o, 1'b0)
        // A port write while halted is dropped and the latch holds.
        @(posedge clk_sys_i);
        irq_pending_i <= 1'b0;
        core.wr(8'h5a);
        @(posedge clk_sys_i);
        core.halt();
        core.wr(8'ha5);
        #1;
        `CHK(port_out_o, 8'h5a)
        // A pin edge in this HALT gives exactly one count pulse.
        @(posedge clk_sys_i);
        timer51_ext_count_pin <= 1'b1;
        // Sampled just after each edge, once the pulse register has settled.
        repeat (8) begin
            @(posedge clk_sys_i);
            #1;
            if (timer51_count_o === 1'b1) n++;
        end
        `CHK(n, 1)
        // A halt in the wake cycle is refused.
        @(posedge clk_sys_i);
        irq_pending_i <= 1'b1;
        @(posedge clk_sys_i);
        irq_pending_i <= 1'b0;
        core.halt();
        #1;
        `CHK({in_halt_o, cpu_clk_en_o}, 2'h1)
        // Reset in mid-HALT restores the core clock and clears the latch.
        @(posedge clk_sys_i);
        core.halt();
        rst_i <= 1'b1;
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        `CHK({in_halt_o, cpu_clk_en_o, en, port_out_o}, 16'h7f00)
        finish_test();
    end
endmodule

// ---- inc/hmc_pkg.sv ----
// Package of constants and types for the HALT-mode clock gating block.
package hmc_pkg;

    // Clock source that is driving the processor when the halt instruction is seen.
    typedef enum logic [1:0] {
        HMC_SRC_HIGH_SPEED,
        HMC_SRC_INTERNAL_OSC,
        HMC_SRC_SUBSYSTEM
    } hmc_src_t;

    // Operating state of the standby controller.
    typedef enum logic [1:0] {
        HMC_ST_RUN,
        HMC_ST_HALT,
        HMC_ST_WAKE
    } hmc_state_t;

    // Count clock selection of the second interval timer, internal_osc_freq / 2^7.
    localparam int unsigned HMC_ITB_DIV_EXP = 7;
    // Synchroniser depth for pin inputs.
    localparam int unsigned HMC_SYNC_STAGES = 3;
    // Reset value of the held port latches.
    localparam logic [7:0]  HMC_PORT_RESET  = 8'h00;

endpackage

// ---- logic/hmc_halt_ctrl.sv ----
// HALT-mode controller: gates the core clock and selects which peripherals keep running.
`timescale 1ns/1ps

module hmc_halt_ctrl
    import hmc_pkg::*;
#(
    parameter int unsigned PORT_W = 8
) (
    // Clock and reset.
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Core interface.
    input  wire logic              halt_instr_i,
    input  wire hmc_src_t          cpu_src_i,
    input  wire logic              irq_pending_i,
    // Configuration straps and peripheral status.
    input  wire logic              osc_nonstop_i,
    input  wire logic              timer50_running_i,
    input  wire logic              itb_div7_sel_i,
    input  wire logic              itb_sub_sel_i,
    // Port latch write path from the core.
    input  wire logic              port_we_i,
    input  wire logic [PORT_W-1:0] port_wdata_i,
    // External count pin of the second 8-bit counter.
    input  wire logic              timer51_ext_count_pin,
    // Gating enables.
    output logic                   cpu_clk_en_o,
    output logic                   osc_run_o,
    output logic                   tmr16_en_o,
    output logic                   tmr50_en_o,
    output logic                   tmr51_en_o,
    output logic                   timer51_count_o,
    output logic                   interval_timer_a_en_o,
    output logic                   interval_timer_b_en_o,
    output logic                   wdt_en_o,
    output logic                   in_halt_o,
    output logic [PORT_W-1:0]      port_out_o
);

    // Elaboration check on the port width.
    if (PORT_W < 1 || PORT_W > 32) begin : g_bad_width
        $error("PORT_W must lie between 1 and 32");
    end

    hmc_state_t        state_reg;
    hmc_state_t        state_next;
    hmc_src_t          src_reg;
    logic              cpu_en_reg;
    logic              tmr16_reg;
    logic              tmr50_reg;
    logic              tmr51_reg;
    logic              t51_cnt_reg;
    logic              ita_reg;
    logic              itb_reg;
    logic              wdt_reg;
    logic              halt_reg;
    logic [PORT_W-1:0] port_reg;
    logic              pin_lvl_w;
    logic              pin_prev_reg;

    // The count pin comes from outside, so it is filtered before use.
    hmc_pin_sync #(
        .RESET_VAL (0)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (timer51_ext_count_pin),
        .level_o   (pin_lvl_w)
    );

    // Decoding of the halt conditions.
    wire halting_w   = (state_reg == HMC_ST_HALT);
    wire enter_w     = (state_reg == HMC_ST_RUN) && halt_instr_i && !irq_pending_i;
    wire wake_w      = halting_w && irq_pending_i;
    wire from_int_w  = (src_reg == HMC_SRC_INTERNAL_OSC);
    wire halt_next_w = (state_next == HMC_ST_HALT);
    wire pin_rise_w  = pin_lvl_w && !pin_prev_reg;

    // Peripheral enables in the next state; internal-oscillator HALT limits them.
    wire int_halt_w  = halt_next_w && (enter_w ? (cpu_src_i == HMC_SRC_INTERNAL_OSC)
                                               : from_int_w);
    wire tmr16_nx_w  = !int_halt_w;
    wire tmr50_nx_w  = !int_halt_w;
    wire tmr51_nx_w  = !int_halt_w;
    wire ita_nx_w    = !int_halt_w || timer50_running_i;
    wire itb_nx_w    = !int_halt_w || (itb_div7_sel_i && !itb_sub_sel_i);
    wire wdt_nx_w    = !int_halt_w || osc_nonstop_i;

    // Next-state logic; the wake state lasts one cycle after exit and refuses halts while the core clock already runs.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            HMC_ST_RUN: begin
                if (enter_w) begin
                    state_next = HMC_ST_HALT;
                end
            end
            HMC_ST_HALT: begin
                if (wake_w) begin
                    state_next = HMC_ST_WAKE;
                end
            end
            HMC_ST_WAKE: begin
                state_next = HMC_ST_RUN;
            end
        endcase
    end

    // State and captured source; reset always lands in run.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg <= HMC_ST_RUN;
            src_reg   <= HMC_SRC_HIGH_SPEED;
        end else begin
            state_reg <= state_next;
            if (enter_w) begin
                src_reg <= cpu_src_i;
            end
        end
    end

    // Core clock gate and peripheral enables, registered so outputs come from flops.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cpu_en_reg <= 1'b1;
            halt_reg   <= 1'b0;
            tmr16_reg  <= 1'b1;
            tmr50_reg  <= 1'b1;
            tmr51_reg  <= 1'b1;
            ita_reg    <= 1'b1;
            itb_reg    <= 1'b1;
            wdt_reg    <= 1'b1;
        end else begin
            cpu_en_reg <= !halt_next_w;
            halt_reg   <= halt_next_w;
            tmr16_reg  <= tmr16_nx_w;
            tmr50_reg  <= tmr50_nx_w;
            tmr51_reg  <= tmr51_nx_w;
            ita_reg    <= ita_nx_w;
            itb_reg    <= itb_nx_w;
            wdt_reg    <= wdt_nx_w;
        end
    end

    // Second 8-bit counter keeps a pin-clocked tick even when its internal clock is cut.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_prev_reg <= 1'b0;
            t51_cnt_reg  <= 1'b0;
        end else begin
            pin_prev_reg <= pin_lvl_w;
            t51_cnt_reg  <= pin_rise_w;
        end
    end

    // Port latches accept writes only while the core runs, so pins hold during HALT.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            port_reg <= PORT_W'(HMC_PORT_RESET);
        end else if (port_we_i && !halting_w) begin
            port_reg <= port_wdata_i;
        end
    end

    // The oscillator is never stopped by this block; HALT gates the core and, from the internal oscillator, peripheral enables.
    assign osc_run_o             = 1'b1;
    assign cpu_clk_en_o          = cpu_en_reg;
    assign in_halt_o             = halt_reg;
    assign tmr16_en_o            = tmr16_reg;
    assign tmr50_en_o            = tmr50_reg;
    assign tmr51_en_o            = tmr51_reg;
    assign timer51_count_o       = t51_cnt_reg;
    assign interval_timer_a_en_o = ita_reg;
    assign interval_timer_b_en_o = itb_reg;
    assign wdt_en_o              = wdt_reg;
    assign port_out_o            = port_reg;

endmodule

// ---- logic/hmc_pin_sync.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps

module hmc_pin_sync
    import hmc_pkg::*;
#(
    parameter int unsigned RESET_VAL = 0
) (
    // Clock and reset.
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Pin side and filtered level.
    input  wire logic pin_i,
    output logic      level_o
);

    // Elaboration check: a one-bit chain can only reset to a zero or a one.
    if (RESET_VAL > 1) begin : g_bad_reset
        $error("RESET_VAL must be 0 or 1");
    end

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    wire  agree_w = (s2_reg == s3_reg);

    // Only the second stage reads the first; the level moves when the last two agree.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s1_reg    <= 1'(RESET_VAL);
            s2_reg    <= 1'(RESET_VAL);
            s3_reg    <= 1'(RESET_VAL);
            level_reg <= 1'(RESET_VAL);
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree_w) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign level_o = level_reg;

endmodule
